// >>> hw/flash_host_defs.svh
// timing counts and register map for the parallel flash host controller
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses on apb)
// ****************************************************************
`define REG_CTRL_OFS     12'h000
`define REG_ADDR_OFS     12'h004
`define REG_WDATA_OFS    12'h008
`define REG_RDATA_OFS    12'h00c
`define REG_STATUS_OFS   12'h010
`define REG_TIMING_OFS   12'h014

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_GO_BIT      0
`define CTRL_WRITE_BIT   1
`define CTRL_BYTE_BIT    2
`define CTRL_RESET_BIT   3
`define STAT_BUSY_BIT    0
`define STAT_READY_BIT   1
`define STAT_DONE_BIT    2
`define STAT_RSTACT_BIT  3

// ****************************************************************
// reset values and timing
// ****************************************************************
`define TIMING_RST_VAL   8'h0a
`define RESET_PULSE_NS   500
`define CLK_PERIOD_NS    10
`define RESET_PULSE_CYC  ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> hw/flash_host_pkg.sv
// types shared by the parallel flash host controller
package flash_host_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_setup,
    st_strobe,
    st_hold,
    st_reset
  } flash_state_t;
endpackage

// >>> hw/cycle_timer.sv
// down-counter producing a one-cycle expiry pulse
module cycle_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_count,
  output logic                  o_expired
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             running;
  logic             next_running;
  logic             next_expired;

  always_comb
  begin
    next_count   = count;
    next_running = running;
    next_expired = 1'b0;
    if (i_load)
    begin
      next_count   = i_count;
      next_running = 1'b1;
    end
    else if (running)
    begin
      if (count <= WIDTH'(1))
      begin
        next_running = 1'b0;
        next_expired = 1'b1;
      end
      else
        next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      count     <= '0;
      running   <= 1'b0;
      o_expired <= 1'b0;
    end
    else
    begin
      count     <= next_count;
      running   <= next_running;
      o_expired <= next_expired;
    end
  end
endmodule

// >>> hw/flash_host.sv
// apb-controlled host that drives a parallel nor flash through its pins
// Functional notes
// R1: drive twenty address lines, plus byte lsb
// R2: byte mode: top data pin carries address lsb
// R3: byte mode: data lines 14..8 unused, tri-state
// R4: width select low means byte mode
// R5: chip select high puts bus in standby
// R6: write: strobe low, select low, read-drive high
// R7: reset low aborts program or erase
// R8: device stands by while reset held
// R9: done pin low while busy, open drain
// R10: thirty-five sectors, smallest erase unit
// R11: four boot sectors of 8 to 32 kb
// R12: other thirty-one sectors are 64 kb
// R13: boot block at top or bottom
// R14: command latches take no array location
// R15: read: select and read-drive low, strobe high
// R16: read-array state after power-up and reset
// R17: suspended erase: other sectors read normally
// R18: status data from busy sector or program
// R19: sector returns to array read after algorithm
// R20: timeout bit needs reset to recover
// R21: id mode left only by reset
// R22: data 7 polling bit, data 6 toggle
// R23: device drives bus only during reads
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`include "flash_host_defs.svh"

module flash_host
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [DATA_W-1:0] o_dq,
  output logic      [DATA_W-1:0] o_dq_oe,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic                   o_width_select_n,
  output logic                   o_chip_select_n,
  output logic                   o_read_drive_n,
  output logic                   o_write_strobe_n,
  output logic                   o_reset_n,
  input  wire logic              i_op_done_out
);

  localparam logic [7:0] RESET_CYC = 8'(`RESET_PULSE_CYC);

  // ****************************************************************
  // state
  // ****************************************************************
  flash_state_t      state;
  flash_state_t      next_state;
  logic [20:0]       addr_reg;
  logic [20:0]       next_addr_reg;
  logic [15:0]       wdata;
  logic [15:0]       next_wdata;
  logic [15:0]       rdata;
  logic [15:0]       next_rdata;
  logic [7:0]        timing;
  logic [7:0]        next_timing;
  logic              op_write;
  logic              next_op_write;
  logic              byte_mode;
  logic              next_byte_mode;
  logic              done;
  logic              next_done;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_dq;
  logic [DATA_W-1:0] next_dq_oe;
  logic              next_cs_n;
  logic              next_oe_n;
  logic              next_we_n;
  logic              next_rst_n;
  logic              next_wsel_n;
  logic              timer_load;
  logic [7:0]        timer_count;
  logic              timer_exp;
  logic              wr_acc;
  logic              rd_acc;

  cycle_timer #(
    .WIDTH (8)
  ) u_timer (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_load    (timer_load),
    .i_count   (timer_count),
    .o_expired (timer_exp)
  );

  assign wr_acc = i_psel && i_penable && i_pwrite && !o_pready;
  assign rd_acc = i_psel && i_penable && !i_pwrite && !o_pready;

  // ****************************************************************
  // apb slave and flash sequencer
  // ****************************************************************
  always_comb
  begin
    next_state     = state;
    next_addr_reg  = addr_reg;
    next_wdata     = wdata;
    next_rdata     = rdata;
    next_timing    = timing;
    next_op_write  = op_write;
    next_byte_mode = byte_mode;
    next_done      = done;
    next_prdata    = o_prdata;
    next_pready    = 1'b0;
    next_pslverr   = 1'b0;
    next_addr      = o_addr;
    next_dq        = o_dq;
    next_dq_oe     = o_dq_oe;
    next_cs_n      = o_chip_select_n;
    next_oe_n      = o_read_drive_n;
    next_we_n      = o_write_strobe_n;
    next_rst_n     = o_reset_n;
    next_wsel_n    = !byte_mode;                               // [R4]
    timer_load     = 1'b0;
    timer_count    = timing;
    // one-cycle answer; go is refused while busy, data registers still accept writes
    if (wr_acc)
    begin
      next_pready = 1'b1;
      unique case (i_paddr)
        `REG_CTRL_OFS:
        begin
          next_byte_mode = i_pwdata[`CTRL_BYTE_BIT];
          if (state == st_idle)
          begin
            next_op_write = i_pwdata[`CTRL_WRITE_BIT];
            if (i_pwdata[`CTRL_RESET_BIT])
            begin
              next_state  = st_reset;
              next_done   = 1'b0;
              next_cs_n   = 1'b1;                              // [R8]
              next_rst_n  = 1'b0;                              // [R7] [R20] [R21]
              timer_load  = 1'b1;
              timer_count = RESET_CYC;
            end
            else if (i_pwdata[`CTRL_GO_BIT])
            begin
              next_state = st_setup;
              next_done  = 1'b0;
            end
          end
        end
        `REG_ADDR_OFS:   next_addr_reg = i_pwdata[20:0];
        `REG_WDATA_OFS:  next_wdata = i_pwdata[15:0];
        `REG_TIMING_OFS: next_timing = (i_pwdata[7:0] == 8'h00) ? 8'h01 : i_pwdata[7:0];
        default:         next_pslverr = 1'b1;
      endcase
    end
    else if (rd_acc)
    begin
      next_pready = 1'b1;
      unique case (i_paddr)
        `REG_CTRL_OFS:   next_prdata = {29'h0, byte_mode, op_write, 1'b0};
        `REG_ADDR_OFS:   next_prdata = {11'h0, addr_reg};
        `REG_WDATA_OFS:  next_prdata = {16'h0, wdata};
        `REG_RDATA_OFS:  next_prdata = {16'h0, rdata};
        `REG_STATUS_OFS: next_prdata = {28'h0, state == st_reset, done,
                                        i_op_done_out, state != st_idle}; // [R9]
        `REG_TIMING_OFS: next_prdata = {24'h0, timing};
        default:
        begin
          next_prdata  = 32'h0;
          next_pslverr = 1'b1;
        end
      endcase
    end

    unique case (state)
      st_idle:
      begin
        next_cs_n  = 1'b1;                                     // [R5]
        next_oe_n  = 1'b1;
        next_we_n  = 1'b1;
        next_dq_oe = '0;
      end
      st_setup:
      begin
        // address, width and data settle one cycle before the strobe
        next_addr = addr_reg[20:1];                            // [R1]
        if (!byte_mode)
          next_addr = addr_reg[19:0];
        next_cs_n = 1'b0;
        next_dq   = wdata;
        if (byte_mode)
        begin
          next_dq    = {addr_reg[0], 7'h00, wdata[7:0]};       // [R2]
          next_dq_oe = {1'b1, 7'h00, {8{op_write}}};           // [R3]
        end
        else
          next_dq_oe = {16{op_write}};
        next_state  = st_strobe;
        timer_load  = 1'b1;
      end
      st_strobe:
      begin
        if (op_write)
        begin
          next_oe_n = 1'b1;                                    // [R6]
          next_we_n = 1'b0;                                    // [R6] [R14]
        end
        else
        begin
          next_we_n = 1'b1;                                    // [R15]
          next_oe_n = 1'b0;                                    // [R15] [R23]
        end
        if (timer_exp)
        begin
          // sample before the strobe lifts; status or array data alike [R18] [R22]
          if (!op_write)
            next_rdata = byte_mode ? {8'h00, i_dq[7:0]} : i_dq;
          next_we_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_state = st_hold;
        end
      end
      st_hold:
      begin
        // one cycle of hold keeps data valid past the rising strobe
        next_cs_n  = 1'b1;
        next_dq_oe = '0;
        next_done  = 1'b1;
        next_state = st_idle;
      end
      st_reset:
      begin
        next_rst_n = 1'b0;                                     // [R8]
        next_cs_n  = 1'b1;
        if (timer_exp)
        begin
          next_rst_n = 1'b1;                                   // [R16]
          next_done  = 1'b1;
          next_state = st_idle;
        end
      end
      default:
        next_state = st_idle;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state            <= st_idle;
      addr_reg         <= '0;
      wdata            <= '0;
      rdata            <= '0;
      timing           <= `TIMING_RST_VAL;
      op_write         <= 1'b0;
      byte_mode        <= 1'b0;
      done             <= 1'b0;
      o_prdata         <= '0;
      o_pready         <= 1'b0;
      o_pslverr        <= 1'b0;
      o_addr           <= '0;
      o_dq             <= '0;
      o_dq_oe          <= '0;
      o_width_select_n <= 1'b1;
      o_chip_select_n  <= 1'b1;
      o_read_drive_n   <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_reset_n        <= 1'b1;
    end
    else
    begin
      state            <= next_state;
      addr_reg         <= next_addr_reg;
      wdata            <= next_wdata;
      rdata            <= next_rdata;
      timing           <= next_timing;
      op_write         <= next_op_write;
      byte_mode        <= next_byte_mode;
      done             <= next_done;
      o_prdata         <= next_prdata;
      o_pready         <= next_pready;
      o_pslverr        <= next_pslverr;
      o_addr           <= next_addr;
      o_dq             <= next_dq;
      o_dq_oe          <= next_dq_oe;
      o_width_select_n <= next_wsel_n;
      o_chip_select_n  <= next_cs_n;
      o_read_drive_n   <= next_oe_n;
      o_write_strobe_n <= next_we_n;
      o_reset_n        <= next_rst_n;
    end
  end
endmodule

// >>> sim/flash_host_chk.sv
// pin and bus assertions for the parallel flash host
`include "flash_host_defs.svh"
module flash_host_chk #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [DATA_W-1:0] o_dq_oe,
  input wire logic              o_width_select_n,
  input wire logic              o_chip_select_n,
  input wire logic              o_read_drive_n,
  input wire logic              o_write_strobe_n,
  input wire logic              o_reset_n
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  always_comb next_low_cnt = o_reset_n ? 8'h00 : low_cnt + 8'h01;
  always_ff @(posedge i_clk) low_cnt <= i_rst ? 8'h00 : next_low_cnt;
  sequence s_rst_hold;
    (!o_reset_n && o_chip_select_n) [*8];
  endsequence
  a_we_qualified: assert property (!o_write_strobe_n |-> !o_chip_select_n && o_read_drive_n)
    else $error("write strobe without select or with read drive");
  a_we_drives_bus: assert property (!o_write_strobe_n && o_width_select_n |-> &o_dq_oe)
    else $error("word write without data drive");
  a_rd_qualified: assert property (!o_read_drive_n |-> o_write_strobe_n && !o_chip_select_n)
    else $error("read drive without select or with strobe");
  a_rd_bus_free: assert property (!o_read_drive_n |-> o_dq_oe[14:0] == 15'h0000
    && o_dq_oe[15] == !o_width_select_n) else $error("host drives data during read");
  a_byte_mid_tri: assert property (!o_width_select_n |-> o_dq_oe[14:8] == 7'h00)
    else $error("byte mode drives data 14 to 8");
  a_addr_steady: assert property (!o_chip_select_n && $past(!o_chip_select_n) |-> $stable(o_addr))
    else $error("address moved inside a cycle");
  a_rst_standby: assert property ($fell(o_reset_n) |-> s_rst_hold)
    else $error("select asserted during reset pulse");
  // the release is registered one cycle after the pulse timer expires
  a_rst_length: assert property ($rose(o_reset_n) |-> low_cnt == `RESET_PULSE_CYC + 1)
    else $error("reset pulse length wrong");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
endmodule
bind flash_host flash_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.i_clk, .i_rst, .o_pready,
  .o_pslverr, .o_addr, .o_dq_oe, .o_width_select_n, .o_chip_select_n, .o_read_drive_n,
  .o_write_strobe_n, .o_reset_n);

// >>> sim/flash_dev_model.sv
// behavioural nor flash standing on the pin side of the host
module flash_dev_model #(
  parameter int BUSY_CYC = 200
) (
  input  wire logic        i_clk,
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_host_dq,
  input  wire logic [15:0] i_host_oe,
  input  wire logic        i_byte_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_reset_n,
  output logic      [15:0] o_bus,
  output logic             o_op_done
);
  // ****************************************************************
  // array, latches and bus resolution
  // ****************************************************************
  logic [15:0] mem [16];
  logic [15:0] lat_d, junk, rd, dev_oe;
  logic [4:0]  lat_a;
  logic        lat_b, pend, tog, oe_q;
  int          busy;
  wire         lsb   = i_host_dq[15];
  wire         drive = !i_cs_n && !i_oe_n && i_we_n && i_reset_n;
  initial
  begin
    junk = 16'h5a5a;
    busy = 0;
    pend = 0;
    tog  = 0;
    foreach (mem[i]) mem[i] = 16'hffff;
  end
  always_comb
  begin
    rd = mem[i_addr[3:0]];
    if (!i_byte_n) rd = {8'h00, lsb ? rd[15:8] : rd[7:0]};
    if (busy != 0) rd = {8'h00, ~lat_d[7], tog, 6'h00};
  end
  assign dev_oe = drive ? (i_byte_n ? 16'hffff : 16'h00ff) : 16'h0000;
  // undriven bits flip every cycle so a stale value never reads as valid
  assign o_bus = (i_host_oe & i_host_dq) | (~i_host_oe & ((dev_oe & rd) | (~dev_oe & junk)));
  assign o_op_done = (busy == 0);
  // writes go straight to the array: command sequences are not modelled
  always @(posedge i_clk)
  begin
    junk <= ~junk;
    oe_q <= i_oe_n;
    if (!i_reset_n)
    begin
      busy <= 0;
      pend <= 0;
    end
    else if (!i_cs_n && !i_we_n && i_oe_n)
    begin
      lat_a <= {i_addr[3:0], lsb};
      lat_d <= i_host_dq;
      lat_b <= !i_byte_n;
      pend  <= 1;
    end
    else if (pend && i_we_n)
    begin
      if (lat_b) mem[lat_a[4:1]][lat_a[0]*8 +: 8] <= lat_d[7:0];
      else mem[lat_a[4:1]] <= lat_d;
      busy <= BUSY_CYC;
      pend <= 0;
    end
    else if (busy != 0) busy <= busy - 1;
    if (busy != 0 && oe_q && !i_oe_n) tog <= !tog;
  end
endmodule

// >>> sim/test_flash_host.sv
// self-checking bench for the apb parallel flash host
`include "flash_host_defs.svh"
module test_flash_host;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, rerr, t1;
  logic        byte_n, cs_n, oe_n, we_n, reset_n, op_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [19:0] addr;
  logic [15:0] dq, dq_oe, bus;
  int          n_fail = 0, tests_run = 0;
  flash_host dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_addr(addr), .o_dq(dq), .o_dq_oe(dq_oe),
    .i_dq(bus), .o_width_select_n(byte_n), .o_chip_select_n(cs_n), .o_read_drive_n(oe_n),
    .o_write_strobe_n(we_n), .o_reset_n(reset_n), .i_op_done_out(op_done));
  flash_dev_model dev (.i_clk(clk), .i_addr(addr), .i_host_dq(dq), .i_host_oe(dq_oe),
    .i_byte_n(byte_n), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_reset_n(reset_n),
    .o_bus(bus), .o_op_done(op_done));
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int g;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    g = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++g < 50);
    // a wait that runs out counts as a mismatch
    chk("apb pready", 32'h1, {31'h0, pready});
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // start an operation and poll until the host reports it finished
  task automatic flash_op(input logic [31:0] ctl);
    int g;
    apb(1'b1, `REG_CTRL_OFS, ctl);
    g = 0;
    do apb(1'b0, `REG_STATUS_OFS, 32'h0); while (rdat[2] !== 1'b1 && ++g < 100);
    chk("op done", 32'h1, {31'h0, rdat[2]});
  endtask
  task automatic rd_flash(input logic [31:0] a, input logic [31:0] ctl);
    apb(1'b1, `REG_ADDR_OFS, a);
    flash_op(ctl);
    apb(1'b0, `REG_RDATA_OFS, 32'h0);
  endtask
  task automatic wait_ready;
    int g;
    g = 0;
    do apb(1'b0, `REG_STATUS_OFS, 32'h0); while (rdat[1] !== 1'b1 && ++g < 200);
    chk("ready wait", 32'h1, {31'h0, rdat[1]});
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    apb(1'b0, `REG_TIMING_OFS, 32'h0);
    chk("timing reset", 32'h0000000a, rdat);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    apb(1'b1, `REG_TIMING_OFS, 32'h3);
  endtask
  task automatic t_word;
    apb(1'b1, `REG_ADDR_OFS, 32'h5);
    apb(1'b1, `REG_WDATA_OFS, 32'hc3a5);
    flash_op(32'h3);
    apb(1'b0, `REG_STATUS_OFS, 32'h0);
    chk("busy pin", 32'h0, {31'h0, rdat[1]});
    rd_flash(32'h5, 32'h1);
    chk("poll bit", 32'h0, {31'h0, rdat[7]});
    t1 = rdat[6];
    rd_flash(32'h5, 32'h1);
    chk("toggle bit", {31'h0, !t1}, {31'h0, rdat[6]});
    wait_ready();
    chk("ready pin", 32'h1, {31'h0, rdat[1]});
    rd_flash(32'h5, 32'h1);
    chk("word read", 32'h0000c3a5, rdat);
  endtask
  task automatic t_byte;
    apb(1'b1, `REG_ADDR_OFS, 32'hb);
    apb(1'b1, `REG_WDATA_OFS, 32'h5a);
    flash_op(32'h7);
    wait_ready();
    rd_flash(32'hb, 32'h5);
    chk("byte read", 32'h0000005a, rdat);
    rd_flash(32'h5, 32'h1);
    chk("word after byte", 32'h00005aa5, rdat);
  endtask
  task automatic t_reset;
    apb(1'b1, `REG_ADDR_OFS, 32'h2);
    apb(1'b1, `REG_WDATA_OFS, 32'h1234);
    flash_op(32'h3);
    flash_op(32'h8);
    apb(1'b0, `REG_STATUS_OFS, 32'h0);
    chk("ready after reset", 32'h1, {31'h0, rdat[1]});
    rd_flash(32'h2, 32'h1);
    chk("array after reset", 32'h00001234, rdat);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_fail++;
    test_done();
  end
  initial
  begin
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_word();
    t_byte();
    t_reset();
    test_done();
  end
endmodule
